// file: nvmcc_pkg.sv
package nvmcc_pkg;

    // ------------------------------------------------------------
    // register offsets (word index, wishbone byte address = 4*index)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_COMMAND_CONTROL      = 4'h0;
    localparam logic [3:0] OFS_SECTION_LOCK_CONTROL = 4'h1;
    localparam logic [3:0] OFS_BUSY_ERROR_STATUS    = 4'h2;
    localparam logic [3:0] OFS_READY_INT_ENABLE     = 4'h3;
    localparam logic [3:0] OFS_READY_INT_FLAG       = 4'h4;
    localparam logic [3:0] OFS_DATA_LOW             = 4'h6;
    localparam logic [3:0] OFS_DATA_HIGH            = 4'h7;
    localparam logic [3:0] OFS_ADDR_LOW             = 4'h8;
    localparam logic [3:0] OFS_ADDR_HIGH            = 4'h9;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_APP_CODE_WRITE_PROTECT = 0;
    localparam int BIT_BOOT_LOCK_A            = 1;
    localparam int BIT_FLASH_BUSY             = 0;
    localparam int BIT_EEPROM_BUSY            = 1;
    localparam int BIT_WRITE_ERROR            = 2;
    localparam int BIT_EEPROM_READY           = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE         = 3'h0,
        CMD_PAGE_WRITE   = 3'h1,
        CMD_PAGE_ERASE   = 3'h2,
        CMD_ERASE_WRITE  = 3'h3,
        CMD_BUFFER_CLEAR = 3'h4,
        CMD_CHIP_ERASE   = 3'h5,
        CMD_EEPROM_ERASE = 3'h6,
        CMD_FUSE_WRITE   = 3'h7
    } nvmcc_cmd_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ           = 40_000_000;
    localparam int SHORT_OP_US      = 2000;
    localparam int LONG_OP_US       = 4000;
    localparam int SHORT_OP_CYCLES  = SHORT_OP_US * (CLK_HZ / 1_000_000);
    localparam int LONG_OP_CYCLES   = LONG_OP_US * (CLK_HZ / 1_000_000);
    localparam int CLEAR_CYCLES     = 7;
    localparam int KEY_WINDOW_INSNS = 4;

    // eeprom occupies addresses at and above this base
    localparam logic [15:0] EEPROM_BASE = 16'h1400;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CLEAR = 4'b0010,
        ST_BUSY  = 4'b0100,
        ST_SLEEP = 4'b1000
    } nvmcc_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [5:0]  adr;
        logic [31:0] dat;
    } nvmcc_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } nvmcc_wb_rsp_t;

    typedef struct packed {
        nvmcc_state_t state;
        logic [2:0]   cmd;
        logic [27:0]  cnt;
        logic [2:0]   key_cnt;
        logic         app_wp;
        logic         boot_lock;
        logic         boot_lock_pend;
        logic         was_in_boot;
        logic         flash_busy;
        logic         eeprom_busy;
        logic         write_error;
        logic         ready_en;
        logic         ready_flag;
        logic [15:0]  data;
        logic [15:0]  addr;
        logic         buf_mixed;
        logic         buf_eeprom;
        logic         buf_loaded;
        logic         ack;
        logic [31:0]  rdat;
        logic         buf_clear;
        logic         ee_erase;
        logic         flash_erase;
        logic         ee_halt;
    } nvmcc_regs_t;

endpackage : nvmcc_pkg

// file: nvmcc_top.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module nvmcc_top #(
    parameter int SHORT_CYCLES = nvmcc_pkg::SHORT_OP_CYCLES,
    parameter int LONG_CYCLES  = nvmcc_pkg::LONG_OP_CYCLES
) (
    input  wire logic                     mclk_i,
    input  wire logic                     sys_rst_i,
    input  wire nvmcc_pkg::nvmcc_wb_req_t wb_req_i,
    output nvmcc_pkg::nvmcc_wb_rsp_t      wb_rsp_o,
    input  wire logic                     key_written_i,
    input  wire logic                     insn_retired_i,
    input  wire logic                     debug_port_i,
    input  wire logic                     exec_in_boot_i,
    input  wire logic                     boot_access_i,
    input  wire logic [15:0]              boot_rdata_i,
    output logic [15:0]                   boot_rdata_o,
    input  wire logic                     buf_store_i,
    input  wire logic [15:0]              buf_store_addr_i,
    input  wire logic                     store_app_code_i,
    input  wire logic                     store_boot_i,
    input  wire logic                     eeprom_save_fuse_i,
    input  wire logic                     sleep_req_i,
    input  wire logic                     idle_sleep_i,
    input  wire logic                     wake_i,
    output logic                          sleep_ok_o,
    output logic                          clock_keep_o,
    output logic                          irq_o,
    output logic                          wake_req_o,
    output logic                          buf_clear_o,
    output logic                          flash_erase_o,
    output logic                          eeprom_erase_o,
    output logic                          cpu_halt_o
);

    nvmcc_pkg::nvmcc_regs_t r;
    nvmcc_pkg::nvmcc_regs_t next_r;

    logic        wr_hit;
    logic        rd_hit;
    logic [3:0]  idx;
    logic [7:0]  wbyte;
    logic        key_open;
    logic        target_ee;
    logic [27:0] dur;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one byte register per word; data in lane 0
    assign idx      = wb_req_i.adr[5:2];
    assign wbyte    = wb_req_i.dat[7:0];
    assign wr_hit   = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0] && !r.ack;
    assign rd_hit   = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !r.ack;
    assign key_open = (r.key_cnt != 3'h0) || key_written_i;
    assign target_ee = (r.addr >= nvmcc_pkg::EEPROM_BASE);

    always_comb begin
        dur = 28'(SHORT_CYCLES);
        case (r.cmd)
            nvmcc_pkg::CMD_ERASE_WRITE,
            nvmcc_pkg::CMD_CHIP_ERASE,
            nvmcc_pkg::CMD_EEPROM_ERASE: begin
                dur = 28'(LONG_CYCLES);
            end
            default: begin
                dur = 28'(SHORT_CYCLES);
            end
        endcase
    end

    always_comb begin
        next_r             = r;
        next_r.ack         = rd_hit || (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !r.ack);
        next_r.buf_clear   = 1'b0;
        next_r.ee_erase    = 1'b0;
        next_r.flash_erase = 1'b0;

        if (key_written_i) begin
            next_r.key_cnt = 3'(nvmcc_pkg::KEY_WINDOW_INSNS);
        end else if (insn_retired_i && r.key_cnt != 3'h0) begin
            next_r.key_cnt = r.key_cnt - 3'h1;
        end

        if (buf_store_i) begin
            next_r.addr       = buf_store_addr_i;
            next_r.buf_loaded = 1'b1;
            next_r.buf_eeprom = buf_store_addr_i >= nvmcc_pkg::EEPROM_BASE;
            if (r.buf_loaded && (r.buf_eeprom != (buf_store_addr_i >= nvmcc_pkg::EEPROM_BASE))) begin
                next_r.buf_mixed = 1'b1;
            end
        end

        // arm pending lock on leaving boot
        next_r.was_in_boot = exec_in_boot_i;
        if (r.boot_lock_pend && r.was_in_boot && !exec_in_boot_i) begin
            next_r.boot_lock = 1'b1;
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_hit) begin
            case (idx)
                nvmcc_pkg::OFS_COMMAND_CONTROL: begin
                    if (key_open && r.state == nvmcc_pkg::ST_IDLE) begin
                        next_r.cmd     = wbyte[2:0];
                        next_r.key_cnt = 3'h0;
                    end
                end
                nvmcc_pkg::OFS_SECTION_LOCK_CONTROL: begin
                    if (wbyte[nvmcc_pkg::BIT_APP_CODE_WRITE_PROTECT]) begin
                        next_r.app_wp = 1'b1;
                    end
                    if (wbyte[nvmcc_pkg::BIT_BOOT_LOCK_A] && exec_in_boot_i) begin
                        next_r.boot_lock_pend = 1'b1;
                    end
                end
                nvmcc_pkg::OFS_READY_INT_ENABLE: begin
                    next_r.ready_en = wbyte[nvmcc_pkg::BIT_EEPROM_READY];
                end
                nvmcc_pkg::OFS_READY_INT_FLAG: begin
                    if (wbyte[nvmcc_pkg::BIT_EEPROM_READY]) begin
                        next_r.ready_flag = 1'b0;
                    end
                end
                nvmcc_pkg::OFS_DATA_LOW:  next_r.data[7:0]  = wbyte;
                nvmcc_pkg::OFS_DATA_HIGH: next_r.data[15:8] = wbyte;
                nvmcc_pkg::OFS_ADDR_LOW:  next_r.addr[7:0]  = wbyte;
                nvmcc_pkg::OFS_ADDR_HIGH: next_r.addr[15:8] = wbyte;
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // command sequencer
        // ------------------------------------------------------------
        case (r.state)
            nvmcc_pkg::ST_IDLE: begin
                if (r.cmd != nvmcc_pkg::CMD_NONE) begin
                    next_r.cmd         = nvmcc_pkg::CMD_NONE;
                    next_r.write_error = 1'b0;
                    next_r.cnt         = dur - 28'h1;
                    case (r.cmd)
                        nvmcc_pkg::CMD_BUFFER_CLEAR: begin
                            next_r.cnt   = 28'(nvmcc_pkg::CLEAR_CYCLES - 1);
                            next_r.state = nvmcc_pkg::ST_CLEAR;
                        end
                        nvmcc_pkg::CMD_PAGE_WRITE,
                        nvmcc_pkg::CMD_PAGE_ERASE,
                        nvmcc_pkg::CMD_ERASE_WRITE: begin
                            if (r.buf_mixed || (!target_ee && (r.app_wp && store_app_code_i
                                    || store_boot_i))) begin
                                next_r.write_error = 1'b1;
                            end else begin
                                next_r.state       = nvmcc_pkg::ST_BUSY;
                                next_r.eeprom_busy = target_ee;
                                next_r.flash_busy  = !target_ee;
                            end
                        end
                        nvmcc_pkg::CMD_CHIP_ERASE: begin
                            next_r.state       = nvmcc_pkg::ST_BUSY;
                            next_r.flash_busy  = 1'b1;
                            next_r.eeprom_busy = !eeprom_save_fuse_i;
                            next_r.flash_erase = 1'b1;
                            next_r.ee_erase    = !eeprom_save_fuse_i;
                        end
                        nvmcc_pkg::CMD_EEPROM_ERASE: begin
                            next_r.state       = nvmcc_pkg::ST_BUSY;
                            next_r.eeprom_busy = 1'b1;
                            next_r.ee_erase    = 1'b1;
                            next_r.ee_halt     = 1'b1;
                        end
                        nvmcc_pkg::CMD_FUSE_WRITE: begin
                            if (debug_port_i) begin
                                next_r.state      = nvmcc_pkg::ST_BUSY;
                                next_r.flash_busy = 1'b1;
                            end else begin
                                next_r.write_error = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (sleep_req_i) begin
                    next_r.state = nvmcc_pkg::ST_SLEEP;
                end
            end
            nvmcc_pkg::ST_CLEAR: begin
                if (r.cnt == 28'h0) begin
                    next_r.buf_clear = 1'b1;
                    next_r.state     = nvmcc_pkg::ST_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 28'h1;
                end
            end
            nvmcc_pkg::ST_BUSY: begin
                if (r.cnt == 28'h0) begin
                    next_r.flash_busy  = 1'b0;
                    next_r.eeprom_busy = 1'b0;
                    next_r.ee_halt     = 1'b0;
                    next_r.buf_clear   = 1'b1;
                    next_r.state       = nvmcc_pkg::ST_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 28'h1;
                end
            end
            nvmcc_pkg::ST_SLEEP: begin
                if (wake_i) begin
                    next_r.buf_clear = 1'b1;
                    next_r.state     = nvmcc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_r.state = nvmcc_pkg::ST_IDLE;
            end
        endcase

        // a store landing with the clear survives it: set wins
        if (next_r.buf_clear) begin
            next_r.buf_loaded = buf_store_i;
            next_r.buf_mixed  = 1'b0;
        end

        // flag follows eeprom idle; set wins over clear
        if (next_r.eeprom_busy) begin
            next_r.ready_flag = 1'b0;
        end else if (r.eeprom_busy || (next_r.ready_en && !r.ready_en)) begin
            next_r.ready_flag = 1'b1;
        end else if (r.ready_en && !r.eeprom_busy && r.ready_flag == 1'b0
                     && !(wr_hit && idx == nvmcc_pkg::OFS_READY_INT_FLAG)) begin
            // requests again while eeprom stays idle
            next_r.ready_flag = 1'b1;
        end

        // ------------------------------------------------------------
        // read data
        // ------------------------------------------------------------
        next_r.rdat = 32'h0000_0000;
        if (rd_hit) begin
            case (idx)
                nvmcc_pkg::OFS_COMMAND_CONTROL:      next_r.rdat[2:0] = r.cmd;
                nvmcc_pkg::OFS_SECTION_LOCK_CONTROL: next_r.rdat[1:0] = {r.boot_lock_pend,
                                                                         r.app_wp};
                nvmcc_pkg::OFS_BUSY_ERROR_STATUS:    next_r.rdat[2:0] = {r.write_error,
                                                                         r.eeprom_busy,
                                                                         r.flash_busy};
                nvmcc_pkg::OFS_READY_INT_ENABLE:     next_r.rdat[0]   = r.ready_en;
                nvmcc_pkg::OFS_READY_INT_FLAG:       next_r.rdat[0]   = r.ready_flag;
                nvmcc_pkg::OFS_DATA_LOW:             next_r.rdat[7:0] = r.data[7:0];
                nvmcc_pkg::OFS_DATA_HIGH:            next_r.rdat[7:0] = r.data[15:8];
                nvmcc_pkg::OFS_ADDR_LOW:             next_r.rdat[7:0] = r.addr[7:0];
                nvmcc_pkg::OFS_ADDR_HIGH:            next_r.rdat[7:0] = r.addr[15:8];
                default:                             next_r.rdat      = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset drops any operation in progress
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r       <= '0;
            r.state <= nvmcc_pkg::ST_IDLE;
            r.cmd   <= nvmcc_pkg::CMD_NONE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_rsp_o       = '{ack: r.ack, dat: r.rdat};
    assign boot_rdata_o   = (r.boot_lock && boot_access_i) ? 16'h0000 : boot_rdata_i;
    assign irq_o          = r.ready_en && r.ready_flag;
    assign wake_req_o     = irq_o && idle_sleep_i && (r.state == nvmcc_pkg::ST_SLEEP);
    assign clock_keep_o   = r.flash_busy || r.eeprom_busy || (r.state == nvmcc_pkg::ST_CLEAR);
    assign sleep_ok_o     = (r.state == nvmcc_pkg::ST_SLEEP);
    assign buf_clear_o    = r.buf_clear;
    assign flash_erase_o  = r.flash_erase;
    assign eeprom_erase_o = r.ee_erase;
    // cpu stalls on flash work, buffer clear and a whole eeprom erase;
    // other eeprom work runs beside it
    assign cpu_halt_o     = r.flash_busy || (r.state == nvmcc_pkg::ST_CLEAR)
                            || r.ee_halt;

endmodule : nvmcc_top

// file: nvmcc_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// cpu side: protection key and a steady instruction stream
// ------------------------------------------------------------
module nvmcc_cpu_model (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic unlock_i,
    output logic      key_written_o,
    output logic      insn_retired_o
);
    // key pulse, then one insn per two cycles
    // the stream never pauses, so a late command write really falls outside the window
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            key_written_o  <= 1'b0;
            insn_retired_o <= 1'b0;
        end else begin
            key_written_o  <= unlock_i;
            insn_retired_o <= ~insn_retired_o;
        end
    end
endmodule : nvmcc_cpu_model

// file: nvmcc_asserts.sv
`timescale 1ns/1ps
module nvmcc_asserts #(
    parameter int SHORT_CYCLES = 20,
    parameter int LONG_CYCLES  = 40
) (
    input wire logic                     mclk_i,
    input wire logic                     sys_rst_i,
    input wire nvmcc_pkg::nvmcc_wb_req_t wb_req_i,
    input wire nvmcc_pkg::nvmcc_wb_rsp_t wb_rsp_o,
    input wire logic                     boot_access_i,
    input wire logic [15:0]              boot_rdata_i,
    input wire logic [15:0]              boot_rdata_o,
    input wire logic                     eeprom_save_fuse_i,
    input wire logic                     sleep_req_i,
    input wire logic                     idle_sleep_i,
    input wire logic                     wake_i,
    input wire logic                     sleep_ok_o,
    input wire logic                     clock_keep_o,
    input wire logic                     wake_req_o,
    input wire logic                     buf_clear_o,
    input wire logic                     flash_erase_o,
    input wire logic                     eeprom_erase_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    logic [27:0] keep_cnt;
    // run length of one operation, bounded by the longest command
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            keep_cnt <= 28'h0;
        end else begin
            keep_cnt <= clock_keep_o ? keep_cnt + 28'h1 : 28'h0;
        end
    end
    sequence s_req;
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    endsequence
    sequence s_wake;
        sleep_ok_o && wake_i;
    endsequence
    a_ack_answer: assert property (s_req |=> wb_rsp_o.ack) else $error("no ack");
    a_boot_pass: assert property (!boot_access_i |-> boot_rdata_o == boot_rdata_i)
        else $error("boot data altered");
    a_boot_zero: assert property (boot_access_i && boot_rdata_o != boot_rdata_i
        |-> boot_rdata_o == 16'h0000) else $error("boot data not zero");
    a_clear_single: assert property (buf_clear_o |=> !buf_clear_o)
        else $error("clear pulse too long");
    a_op_bound: assert property (keep_cnt <= LONG_CYCLES + 4)
        else $error("operation too long");
    a_reset_abort: assert property ($fell(sys_rst_i) |-> !clock_keep_o)
        else $error("operation survived reset");
    a_sleep_hold: assert property (sleep_req_i && clock_keep_o |-> !sleep_ok_o)
        else $error("slept during write");
    a_sleep_enter: assert property ((sleep_req_i && !clock_keep_o && !wake_i)[*8]
        |=> sleep_ok_o) else $error("no sleep entry");
    a_wake_clear: assert property (s_wake |-> ##[1:10] buf_clear_o)
        else $error("no clear on wake");
    a_wake_idle: assert property (wake_req_o |-> idle_sleep_i)
        else $error("wake from deep sleep");
    a_erase_save: assert property (flash_erase_o && eeprom_save_fuse_i
        |-> !eeprom_erase_o) else $error("eeprom erased despite save");
endmodule : nvmcc_asserts

bind nvmcc_top nvmcc_asserts #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) chk (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .boot_access_i(boot_access_i), .boot_rdata_i(boot_rdata_i), .boot_rdata_o(boot_rdata_o),
    .eeprom_save_fuse_i(eeprom_save_fuse_i), .sleep_req_i(sleep_req_i),
    .idle_sleep_i(idle_sleep_i), .wake_i(wake_i), .sleep_ok_o(sleep_ok_o),
    .clock_keep_o(clock_keep_o), .wake_req_o(wake_req_o), .buf_clear_o(buf_clear_o),
    .flash_erase_o(flash_erase_o), .eeprom_erase_o(eeprom_erase_o));

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
    localparam int SC = 20;
    localparam int LC = 40;
    localparam logic [2:0] CMDS [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h5, 3'h6};
    localparam int         DUR  [6] = '{SC, SC, LC, LC, LC, LC};
    localparam logic [1:0] SEEN [6] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b11, 2'b01};
    logic                     mclk_i = 1'b0, sys_rst_i = 1'b1, unlock = 1'b0, key, insn;
    logic                     boot_x = 1'b0, acc_b = 1'b0, store = 1'b0, app = 1'b0;
    logic                     save = 1'b0, slp = 1'b0, wake = 1'b0, clr = 1'b1, idle = 1'b1;
    logic                     keep, slp_ok, clr_o, fl_o, ee_o, irq, wak, halt;
    logic [15:0]              saddr = 16'h0000, brd;
    logic [1:0]               seen;
    logic [7:0]               rd;
    nvmcc_pkg::nvmcc_wb_req_t req = '0;
    nvmcc_pkg::nvmcc_wb_rsp_t rsp;
    int                       n_fail = 0, tests_run = 0, cyc_n = 0, n;
    initial forever #12.5 mclk_i = ~mclk_i;
    nvmcc_cpu_model cpu (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .unlock_i(unlock),
        .key_written_o(key), .insn_retired_o(insn));
    nvmcc_top #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC)) uut (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .key_written_i(key),
        .insn_retired_i(insn), .debug_port_i(1'b0), .exec_in_boot_i(boot_x),
        .boot_access_i(acc_b), .boot_rdata_i(16'h5aa5), .boot_rdata_o(brd),
        .buf_store_i(store), .buf_store_addr_i(saddr), .store_app_code_i(app),
        .store_boot_i(1'b0), .eeprom_save_fuse_i(save), .sleep_req_i(slp),
        .idle_sleep_i(idle), .wake_i(wake), .sleep_ok_o(slp_ok), .clock_keep_o(keep),
        .irq_o(irq), .wake_req_o(wak), .buf_clear_o(clr_o), .flash_erase_o(fl_o),
        .eeprom_erase_o(ee_o), .cpu_halt_o(halt));
    always @(posedge mclk_i) begin
        seen <= clr ? 2'b00 : (seen | {fl_o, ee_o});
        cyc_n <= cyc_n + 1;
        if (cyc_n == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // one classic cycle; request held until ack is sampled high
    task automatic acc(input logic w, input logic [3:0] idx, input logic [7:0] d);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: {idx, 2'b00}, dat: {24'h0, d}};
        // no local limit: a missing ack runs into the bench timeout
        do begin
            @(posedge mclk_i);
        end while (rsp.ack !== 1'b1);
        rd = rsp.dat[7:0];
        req <= '0;
        @(posedge mclk_i);
    endtask : acc
    task automatic rchk(input logic [3:0] idx, input logic [7:0] e);
        acc(1'b0, idx, 8'h00);
        `CHK(rd, e)
    endtask : rchk
    task automatic cmd(input logic [2:0] c, input int dly);
        unlock <= 1'b1;
        @(posedge mclk_i);
        unlock <= 1'b0;
        repeat (dly + 1) @(posedge mclk_i);
        acc(1'b1, 4'h0, {5'h00, c});
        repeat (2) @(posedge mclk_i);
    endtask : cmd
    task automatic put(input logic [15:0] a);
        saddr <= a;
        store <= 1'b1;
        @(posedge mclk_i);
        store <= 1'b0;
        @(posedge mclk_i);
    endtask : put
    // sel 0: wait for the operation to end, sel 1: wait for a clear pulse
    task automatic wait_for(input logic sel);
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while ((sel ? clr_o : keep) !== sel && n < 200);
    endtask : wait_for
    initial begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        for (int i = 0; i < 10; i++) rchk(i[3:0], 8'h00);
        put(16'h0123);
        cmd(3'h1, 12);
        rchk(4'h2, 8'h00);
        rchk(4'h8, 8'h23);
        rchk(4'h9, 8'h01);
        for (int i = 0; i < 6; i++) begin
            if (i == 2) begin
                acc(1'b1, 4'h3, 8'h01);
                repeat (2) @(posedge mclk_i);
                `CHK(irq, 1'b1)
                acc(1'b1, 4'h4, 8'h00);
                `CHK(irq, 1'b1)
            end
            clr <= 1'b1;
            save <= (i == 3);
            put(i == 2 ? 16'h1400 : 16'h0123);
            clr <= 1'b0;
            cmd(CMDS[i], 0);
            `CHK(halt, i != 2)
            if (i < 3) rchk(4'h2, i == 2 ? 8'h02 : 8'h01);
            if (i == 2) `CHK(irq, 1'b0)
            if (i == 0) begin
                slp <= 1'b1;
                repeat (2) @(posedge mclk_i);
                `CHK({keep, slp_ok}, 2'b10)
            end
            wait_for(1'b0);
            `CHK(n + 14 > DUR[i] && n <= DUR[i], 1'b1)
            `CHK(seen, SEEN[i])
            if (i == 0) begin
                repeat (9) @(posedge mclk_i);
                `CHK(slp_ok, 1'b1)
                wake <= 1'b1;
                @(posedge mclk_i);
                wake <= 1'b0;
                slp <= 1'b0;
                wait_for(1'b1);
                `CHK(n < 10, 1'b1)
            end
        end
        repeat (2) @(posedge mclk_i);
        `CHK(irq, 1'b1)
        slp <= 1'b1;
        repeat (3) @(posedge mclk_i);
        `CHK({slp_ok, wak}, 2'b11)
        idle <= 1'b0;
        @(posedge mclk_i);
        `CHK(wak, 1'b0)
        wake <= 1'b1;
        @(posedge mclk_i);
        wake <= 1'b0;
        slp  <= 1'b0;
        idle <= 1'b1;
        @(posedge mclk_i);
        acc(1'b1, 4'h3, 8'h00);
        `CHK(irq, 1'b0)
        rchk(4'h4, 8'h01);
        acc(1'b1, 4'h4, 8'h00);
        rchk(4'h4, 8'h01);
        acc(1'b1, 4'h4, 8'h01);
        rchk(4'h4, 8'h00);
        cmd(3'h4, 0);
        wait_for(1'b1);
        `CHK(n < 10, 1'b1)
        cmd(3'h7, 0);
        rchk(4'h2, 8'h04);
        acc(1'b1, 4'h1, 8'h02);
        rchk(4'h1, 8'h00);
        boot_x <= 1'b1;
        acc(1'b1, 4'h1, 8'h03);
        acc(1'b1, 4'h1, 8'h00);
        rchk(4'h1, 8'h03);
        acc_b <= 1'b1;
        @(posedge mclk_i);
        `CHK(brd, 16'h5aa5)
        boot_x <= 1'b0;
        repeat (2) @(posedge mclk_i);
        `CHK(brd, 16'h0000)
        app <= 1'b1;
        put(16'h0123);
        cmd(3'h1, 0);
        rchk(4'h2, 8'h04);
        app <= 1'b0;
        put(16'h0123);
        cmd(3'h1, 0);
        `CHK(keep, 1'b1)
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        `CHK(keep, 1'b0)
        rchk(4'h2, 8'h00);
        stop_test();
    end
endmodule : tb_top
